/* src/mmd_pkg.sv */
// Package with the constants of the memory map and bank decoder.
package mmd_pkg;
    localparam int PC_W = 13;
    localparam int WORD_W = 14;
    localparam int DATA_W = 8;
    localparam int DADDR_W = 8;
    localparam int PMEM_DEPTH = 1024;
    localparam int PMEM_AW = 10;
    localparam int GPR_DEPTH = 64;
    localparam int GPR_AW = 6;
    localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
    localparam logic [6:0] OFS_INDIRECT = 7'h00;
    localparam logic [6:0] OFS_PC_LOW = 7'h02;
    localparam logic [6:0] OFS_STATUS = 7'h03;
    localparam logic [6:0] OFS_POINTER = 7'h04;
    localparam logic [6:0] OFS_PC_LATCH = 7'h0A;
    localparam logic [6:0] OFS_IRQ_CTRL = 7'h0B;
    localparam logic [6:0] SFR_LAST = 7'h1F;
    localparam logic [6:0] GPR_FIRST = 7'h20;
    localparam logic [6:0] GPR_LAST = 7'h5F;
    localparam int BANK_BIT = 5;
    localparam int RSV_BANK_HI_BIT = 6;
    localparam int RSV_IND_BANK_BIT = 7;
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [7:0] PC_LATCH_RST = 8'h00;
    localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
    localparam logic [7:0] POINTER_RST = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage

/* src/mmd_decoder.sv */
// Program and data memory decoder with the core special registers.
`timescale 1ns/10ps
module mmd_decoder
    import mmd_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // Program counter control from the core.
    input wire logic pc_step_in,
    input wire logic pc_load_in,
    input wire logic [mmd_pkg::PC_W-1:0] pc_target_in,
    input wire logic irq_take_in,
    // Program memory load port.
    input wire logic pmem_we_in,
    input wire logic [mmd_pkg::PC_W-1:0] pmem_waddr_in,
    input wire logic [mmd_pkg::WORD_W-1:0] pmem_wdata_in,
    // Data access from the core.
    input wire logic dacc_rd_in,
    input wire logic dacc_wr_in,
    input wire logic [6:0] dacc_addr_in,
    input wire logic [mmd_pkg::DATA_W-1:0] dacc_wdata_in,
    // Fetch outputs.
    output logic [mmd_pkg::PC_W-1:0] pc_out,
    output logic [mmd_pkg::WORD_W-1:0] instr_out,
    // Data read outputs.
    output logic [mmd_pkg::DATA_W-1:0] dacc_rdata_out,
    output logic dacc_rvalid_out,
    output logic [mmd_pkg::DATA_W-1:0] status_out
);
    import mmd_pkg::*;

    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] pc_nxt;
    logic [DATA_W-1:0] status_r;
    logic [DATA_W-1:0] pointer_r;
    logic [DATA_W-1:0] pc_latch_r;
    logic [DATA_W-1:0] irq_ctrl_r;
    logic [WORD_W-1:0] instr_r;
    logic [DATA_W-1:0] rdata_r;
    logic rvalid_r;
    logic [WORD_W-1:0] pmem [PMEM_DEPTH];
    logic [DATA_W-1:0] gpr [GPR_DEPTH];

    // Only the low ten bits reach the array, so higher addresses alias.
    wire [PMEM_AW-1:0] fetch_idx = pc_r[PMEM_AW-1:0];
    wire [PMEM_AW-1:0] load_idx = pmem_waddr_in[PMEM_AW-1:0];

    // Indirect goes through the full pointer; direct adds the bank bit.
    wire is_indirect = (dacc_addr_in == OFS_INDIRECT);
    wire bank_sel = status_r[BANK_BIT];
    wire [DADDR_W-1:0] eff_addr = is_indirect ? pointer_r : {bank_sel, dacc_addr_in};
    // The bank bit is dropped so both banks meet the same locations.
    wire [6:0] bank_ofs = eff_addr[6:0];
    wire is_sfr = (bank_ofs <= SFR_LAST);
    wire is_gpr = (bank_ofs >= GPR_FIRST) && (bank_ofs <= GPR_LAST);
    wire [GPR_AW-1:0] gpr_idx = 6'(bank_ofs - GPR_FIRST);
    // Reading the indirect location through the pointer itself yields zero.
    wire hit_ind = is_sfr && (bank_ofs == OFS_INDIRECT);
    wire hit_pc_low = is_sfr && (bank_ofs == OFS_PC_LOW);
    wire hit_status = is_sfr && (bank_ofs == OFS_STATUS);
    wire hit_pointer = is_sfr && (bank_ofs == OFS_POINTER);
    wire hit_pc_latch = is_sfr && (bank_ofs == OFS_PC_LATCH);
    wire hit_irq_ctrl = is_sfr && (bank_ofs == OFS_IRQ_CTRL);
    wire wr_pc_low = dacc_wr_in && hit_pc_low;

    // Read mux: anything not decoded returns zero.
    wire [DATA_W-1:0] rd_mux =
        hit_ind ? ZERO_BYTE :
        hit_pc_low ? pc_r[7:0] :
        hit_status ? status_r :
        hit_pointer ? pointer_r :
        hit_pc_latch ? pc_latch_r :
        hit_irq_ctrl ? irq_ctrl_r :
        is_gpr ? gpr[gpr_idx] : ZERO_BYTE;

    // Interrupt beats a program counter write, which beats a jump or step.
    always_comb begin
        pc_nxt = pc_r;
        if (irq_take_in) begin
            pc_nxt = IRQ_VECTOR;
        end else if (wr_pc_low) begin
            pc_nxt = {pc_latch_r[4:0], dacc_wdata_in};
        end else if (pc_load_in) begin
            pc_nxt = pc_target_in;
        end else if (pc_step_in) begin
            pc_nxt = PC_W'(pc_r + 13'h0001);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            pc_r <= RESET_VECTOR;
        end else begin
            pc_r <= pc_nxt;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            status_r <= STATUS_RST;
            pointer_r <= POINTER_RST;
            pc_latch_r <= PC_LATCH_RST;
            irq_ctrl_r <= IRQ_CTRL_RST;
        end else if (dacc_wr_in) begin
            if (hit_status) begin
                status_r <= dacc_wdata_in;
            end
            if (hit_pointer) begin
                pointer_r <= dacc_wdata_in;
            end
            if (hit_pc_latch) begin
                pc_latch_r <= {3'h0, dacc_wdata_in[4:0]};
            end
            if (hit_irq_ctrl) begin
                irq_ctrl_r <= dacc_wdata_in;
            end
        end
    end

    // The arrays carry no reset.
    always_ff @(posedge clk_sys_in) begin
        if (dacc_wr_in && is_gpr) begin
            gpr[gpr_idx] <= dacc_wdata_in;
        end
        if (pmem_we_in) begin
            pmem[load_idx] <= pmem_wdata_in;
        end
        instr_r <= pmem[fetch_idx];
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            rdata_r <= ZERO_BYTE;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= dacc_rd_in ? rd_mux : ZERO_BYTE;
            rvalid_r <= dacc_rd_in;
        end
    end

    assign pc_out = pc_r;
    assign instr_out = instr_r;
    assign dacc_rdata_out = rdata_r;
    assign dacc_rvalid_out = rvalid_r;
    assign status_out = status_r;
endmodule

/* dv/mmd_sva.sv */
// Checker for the decoder ports.
`timescale 1ns/10ps
module mmd_sva (
    input wire logic clk_sys_in, srst_in, pc_step_in, pc_load_in, irq_take_in,
    input wire logic dacc_rd_in, dacc_wr_in, dacc_rvalid_out,
    input wire logic [12:0] pc_target_in, pc_out,
    input wire logic [6:0] dacc_addr_in,
    input wire logic [7:0] dacc_wdata_in, dacc_rdata_out, status_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    a_rst_vec: assert property (disable iff (1'b0) srst_in |=> pc_out == 13'h0000)
        else $error("pc not at reset vector");
    a_irq_vec: assert property (irq_take_in |=> pc_out == 13'h0004)
        else $error("pc not at interrupt vector");
    a_load_pc: assert property (pc_load_in && !irq_take_in && !dacc_wr_in |=>
        pc_out == $past(pc_target_in)) else $error("pc load lost");
    a_step_pc: assert property (pc_step_in && !pc_load_in && !irq_take_in && !dacc_wr_in
        |=> pc_out == $past(pc_out) + 13'h1) else $error("pc step wrong");
    a_read_valid: assert property (1 |=> dacc_rvalid_out == $past(dacc_rd_in))
        else $error("read valid timing wrong");
    a_unimpl_zero: assert property (dacc_rd_in && dacc_addr_in >= 7'h60 |=>
        dacc_rdata_out == 8'h00) else $error("unimplemented read not zero");
    a_bank_write: assert property (dacc_wr_in && dacc_addr_in == 7'h03 |=>
        status_out == $past(dacc_wdata_in)) else $error("status write lost");
    a_status_read: assert property (dacc_rd_in && !dacc_wr_in && dacc_addr_in == 7'h03
        |=> dacc_rdata_out == $past(status_out)) else $error("status read wrong");
endmodule

bind mmd_decoder mmd_sva u_sva (.*);

/* dv/mmd_core.sv */
// Core model issuing data accesses one strobe at a time.
`timescale 1ns/10ps
module mmd_core (
    input wire logic clk_sys_in,
    output logic dacc_rd_out, dacc_wr_out,
    output logic [6:0] dacc_addr_out,
    output logic [7:0] dacc_wdata_out
);
    initial {dacc_rd_out, dacc_wr_out, dacc_addr_out, dacc_wdata_out} = '0;
    // The strobe stands over one edge; released data is inverted so it is never reused.
    task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys_in) #2;
        {dacc_rd_out, dacc_wr_out, dacc_addr_out, dacc_wdata_out} = {!w, w, a, d};
        @(posedge clk_sys_in) #2;
        {dacc_rd_out, dacc_wr_out, dacc_wdata_out} = {2'b00, ~d};
    endtask
endmodule

/* dv/mmd_decoder_test.sv */
// Testbench for the memory map and bank decoder.
`timescale 1ns/10ps
module mmd_decoder_test;
    logic clk_sys_in = 0, srst_in = 1, pc_step_in = 0, pc_load_in = 0, irq_take_in = 0;
    logic pmem_we_in = 0, dacc_rd_in, dacc_wr_in, dacc_rvalid_out;
    logic [12:0] pc_target_in = 0, pmem_waddr_in = 0, pc_out;
    logic [13:0] pmem_wdata_in = 0, instr_out;
    logic [6:0] dacc_addr_in;
    logic [7:0] dacc_wdata_in, dacc_rdata_out, status_out;
    int err_count = 0, compares = 0;
    // Columns: bank before write, address, data, bank before read, address, expected.
    logic [7:0] rows [7][6] = '{'{8'h00, 8'h20, 8'h5A, 8'h20, 8'h20, 8'h5A},
        '{8'h00, 8'h5F, 8'hC3, 8'h20, 8'h5F, 8'hC3}, '{8'h00, 8'h60, 8'h77, 8'h00, 8'h60, 8'h00},
        '{8'h20, 8'h04, 8'hA0, 8'h00, 8'h00, 8'h5A}, '{8'h20, 8'h0A, 8'hFF, 8'h00, 8'h0A, 8'h1F},
        '{8'h00, 8'h05, 8'h33, 8'h00, 8'h05, 8'h00}, '{8'h00, 8'h0B, 8'h3C, 8'h20, 8'h0B, 8'h3C}};
    always #25 clk_sys_in = ~clk_sys_in;
    mmd_decoder dut (.*);
    mmd_core core (.clk_sys_in, .dacc_rd_out(dacc_rd_in), .dacc_wr_out(dacc_wr_in),
        .dacc_addr_out(dacc_addr_in), .dacc_wdata_out(dacc_wdata_in));
    task automatic chk(input string n, input logic [13:0] e, s);
        compares++;
        if (s !== e) begin
            $display("Error %s expected %h seen %h", n, e, s);
            err_count++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #2;
    endtask
    task automatic print_verdict;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        tick(20);
        srst_in = 0;
        foreach (rows[i]) begin
            core.acc(1, 7'h03, rows[i][0]);
            core.acc(1, rows[i][1][6:0], rows[i][2]);
            core.acc(1, 7'h03, rows[i][3]);
            core.acc(0, rows[i][4][6:0], 8'h00);
            chk("rdata", rows[i][5], dacc_rdata_out);
        end
        pmem_we_in = 1;
        {pmem_waddr_in, pmem_wdata_in} = {13'h0404, 14'h2ABC};
        tick(1);
        {pmem_waddr_in, pmem_wdata_in} = {13'h0005, 14'h1234};
        tick(1);
        {pmem_we_in, irq_take_in} = 2'b01;
        tick(1);
        irq_take_in = 0;
        tick(1);
        chk("pc", 13'h0004, pc_out);
        chk("instr", 14'h2ABC, instr_out);
        {pc_target_in, pc_load_in} = {13'h1005, 1'b1};
        tick(1);
        {pc_load_in, pc_step_in} = 2'b01;
        chk("pc", 13'h1005, pc_out);
        tick(1);
        {pc_step_in, srst_in} = 2'b01;
        chk("pc", 13'h1006, pc_out);
        chk("instr", 14'h1234, instr_out);
        tick(1);
        srst_in = 0;
        chk("pc", 13'h0000, pc_out);
        chk("status", 8'h18, status_out);
        print_verdict;
    end
endmodule
